/* File: ols_pkg.sv */
/*
  Constants, register map and carrier types for the optical link supervisor.
  Assumes a 40 MHz pclk and that the analog front end reports received margin
  and emission power as 8-bit codes.
*/
// What this block does
// R1: The operating mode selector is sampled once after power-up and held until the next power-up.
// R2: The high level lamp lights at margin 2x, the low level lamp at 1.5x and the carrier lamp at 1x.
// R3: The optical link lamp lights only while the optical link with the peer is established.
// R4: The status lamp lights while internal circuitry is healthy and is off otherwise; the block also keeps it off in the error state.
// R5: Data passes between optical and wired sides only when status and carrier are both active.
// R6: Emission power is compared against its window and a fault blinks carrier and both level lamps.
// R7: An emission power fault switches the laser off and enters the error state.
// R8: The error state holds until a power-on restart, after which normal operation is re-checked.
// R9: In normal mode the wired link stays up and the laser keeps emitting while light is interrupted.
// R10: In master or slave mode the wired link drops while light is interrupted; a master keeps emitting.
// R11: In slave mode the laser stays off while the wired link is down.
// R12: Pairs are only normal with normal, master with master, or master with slave.
// R13: On a fieldbus the unit at the bus master is master mode and the unit at a slave is slave mode.
// R14: During alignment both units are master or both normal so that both emit.
// R15: The carrier-detect output is asserted while light from the peer is received.
// R16: The fault blink toggles the three lamps in phase at a fixed rate derived from pclk.
package ols_pkg;
  typedef enum logic [1:0] {MODE_NORMAL, MODE_MASTER, MODE_SLAVE} mode_t;

  typedef struct packed {
    logic status;
    logic level_high;
    logic level_low;
    logic carrier;
    logic link;
  } lamps_t;

  // Margin codes are in quarters of the 1x reception threshold.
  localparam logic [7:0] LVL_CARRIER = 8'h04;
  localparam logic [7:0] LVL_LOW = 8'h06;
  localparam logic [7:0] LVL_HIGH = 8'h08;

  localparam logic [1:0] SW_MASTER = 2'h1;
  localparam logic [1:0] SW_SLAVE = 2'h2;
  localparam logic [1:0] SETTLE_LAST = 2'h3;

  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_W = 24;

  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_PWR_LO = 8'h04;
  localparam logic [7:0] ADDR_PWR_HI = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam logic [7:0] PWR_LO_RESET = 8'h40;
  localparam logic [7:0] PWR_HI_RESET = 8'hC0;

  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_CARRIER_LOST = 1;
  localparam int unsigned EV_CARRIER_GAINED = 2;
  localparam int unsigned EV_LINK_LOST = 3;
  localparam int unsigned EV_N = 4;
endpackage

/* File: optical_link_supervisor.sv */
/*
  Supervisor for one unit of a paired optical Ethernet repeater: mode latch,
  lamps, laser and wired-link control, emission power fault, APB registers.
  Assumes all sensor and switch inputs are asynchronous pins and that presetn
  is the power-on reset.
*/
`timescale 1ns/1ps
module optical_link_supervisor
  import ols_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYCLES
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from the switch and the front end.
  input wire logic [1:0] mode_switch,
  input wire logic [7:0] rx_margin,
  input wire logic [7:0] emit_power,
  input wire logic peer_link,
  input wire logic circuit_ok,
  input wire logic lan_phy_up,
  // Lamps, drives and interrupt.
  output lamps_t lamps,
  output logic carrier_present,
  output logic laser_en,
  output logic lan_link_en,
  output logic pass_en,
  output logic irq
);

  typedef struct packed {
    logic [1:0] sw_m;
    logic [1:0] sw_s;
    logic [7:0] margin_m;
    logic [7:0] margin_s;
    logic [7:0] power_m;
    logic [7:0] power_s;
    logic [2:0] pin_m;
    logic [2:0] pin_s;
    mode_t mode;
    logic [1:0] settle;
    logic mode_valid;
    logic error;
    logic [BLINK_W-1:0] blink_cnt;
    logic blink;
    logic [7:0] pwr_lo;
    logic [7:0] pwr_hi;
    logic [EV_N-1:0] irq_stat;
    logic [EV_N-1:0] irq_mask;
    lamps_t lamps;
    logic carrier_present;
    logic laser_en;
    logic lan_link_en;
    logic pass_en;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s;
  state_t next_s;
  logic carrier_now;
  logic link_now;
  logic ok_now;
  logic lan_up_now;
  logic fault_now;
  logic access;
  logic commit;
  logic [EV_N-1:0] events;
  logic [EV_N-1:0] clear;

  assign carrier_now = s.margin_s >= LVL_CARRIER;
  assign link_now = s.pin_s[0];
  assign ok_now = s.pin_s[1];
  assign lan_up_now = s.pin_s[2];
  // Power is judged only while the laser was already on, since a dark laser reads far below the window.
  assign fault_now = s.laser_en && (s.power_s < s.pwr_lo || s.power_s > s.pwr_hi); // R6
  assign access = psel && penable && !s.pready;
  // Writes land only at the edge where the master sees pready, so an access the master gives up changes nothing.
  assign commit = psel && penable && pwrite && s.pready;

  always_comb begin
    next_s = s;
    events = '0;
    clear = '0;

    // Pins pass two flops before any logic looks at them.
    next_s.sw_m = mode_switch;
    next_s.sw_s = s.sw_m;
    next_s.margin_m = rx_margin;
    next_s.margin_s = s.margin_m;
    next_s.power_m = emit_power;
    next_s.power_s = s.power_m;
    next_s.pin_m = {lan_phy_up, circuit_ok, peer_link};
    next_s.pin_s = s.pin_m;

    // The switch is read once the synchroniser has filled; later moves are ignored.
    if (!s.mode_valid) begin
      if (s.settle == SETTLE_LAST) begin
        next_s.mode_valid = 1'b1; // R1
        unique case (s.sw_s)
          SW_MASTER: next_s.mode = MODE_MASTER; // R1
          SW_SLAVE: next_s.mode = MODE_SLAVE; // R1
          default: next_s.mode = MODE_NORMAL; // R1
        endcase
      end else begin
        next_s.settle = s.settle + 2'h1;
      end
    end

    // Only a power-on reset leaves the error state.
    if (fault_now) begin
      next_s.error = 1'b1; // R7 R8
    end

    if (s.blink_cnt == BLINK_W'(BLINK_CYCLES - 1)) begin
      next_s.blink_cnt = '0;
      next_s.blink = !s.blink; // R16
    end else begin
      next_s.blink_cnt = s.blink_cnt + BLINK_W'(1);
    end

    next_s.lamps.status = ok_now && !s.error; // R4
    next_s.lamps.link = link_now; // R3
    if (s.error) begin
      next_s.lamps.carrier = s.blink; // R6 R16
      next_s.lamps.level_low = s.blink; // R6 R16
      next_s.lamps.level_high = s.blink; // R6 R16
    end else begin
      next_s.lamps.carrier = carrier_now; // R2
      next_s.lamps.level_low = s.margin_s >= LVL_LOW; // R2
      next_s.lamps.level_high = s.margin_s >= LVL_HIGH; // R2
    end
    next_s.carrier_present = carrier_now; // R15
    next_s.pass_en = ok_now && !s.error && carrier_now; // R5

    next_s.laser_en = 1'b0;
    next_s.lan_link_en = 1'b0;
    if (s.mode_valid) begin
      unique case (s.mode)
        MODE_NORMAL: begin
          next_s.lan_link_en = 1'b1; // R9
          next_s.laser_en = !s.error && !fault_now; // R9 R7
        end
        MODE_MASTER: begin
          next_s.lan_link_en = carrier_now; // R10
          next_s.laser_en = !s.error && !fault_now; // R10 R7
        end
        MODE_SLAVE: begin
          next_s.lan_link_en = carrier_now; // R10
          next_s.laser_en = !s.error && !fault_now && lan_up_now; // R11 R7
        end
      endcase
    end

    events[EV_FAULT] = fault_now && !s.error;
    events[EV_CARRIER_LOST] = s.carrier_present && !carrier_now;
    events[EV_CARRIER_GAINED] = !s.carrier_present && carrier_now;
    events[EV_LINK_LOST] = s.lamps.link && !link_now;

    // Registers answer one cycle into the access phase.
    next_s.pready = access;
    next_s.pslverr = 1'b0;
    next_s.prdata = '0;
    if (access || commit) begin
      unique case (paddr)
        ADDR_STATUS: begin
          if (access) begin
            next_s.prdata = {23'h0, s.pass_en, s.lan_link_en, s.laser_en, s.lamps.link,
                             s.carrier_present, s.error, s.mode_valid, s.mode};
            next_s.pslverr = pwrite;
          end
        end
        ADDR_PWR_LO: begin
          if (access) begin
            next_s.prdata = {24'h000000, s.pwr_lo};
          end
          if (commit) begin
            next_s.pwr_lo = pwdata[7:0];
          end
        end
        ADDR_PWR_HI: begin
          if (access) begin
            next_s.prdata = {24'h000000, s.pwr_hi};
          end
          if (commit) begin
            next_s.pwr_hi = pwdata[7:0];
          end
        end
        ADDR_IRQ_STAT: begin
          if (access) begin
            next_s.prdata = {28'h0000000, s.irq_stat};
          end
          if (commit) begin
            clear = pwdata[EV_N-1:0];
          end
        end
        ADDR_IRQ_MASK: begin
          if (access) begin
            next_s.prdata = {28'h0000000, s.irq_mask};
          end
          if (commit) begin
            next_s.irq_mask = pwdata[EV_N-1:0];
          end
        end
        default: next_s.pslverr = access;
      endcase
    end
    // A new event outranks a clear in the same cycle.
    next_s.irq_stat = (s.irq_stat & ~clear) | events;
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.mode <= MODE_NORMAL;
      s.pwr_lo <= PWR_LO_RESET;
      s.pwr_hi <= PWR_HI_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign lamps = s.lamps;
  assign carrier_present = s.carrier_present;
  assign laser_en = s.laser_en;
  assign lan_link_en = s.lan_link_en;
  assign pass_en = s.pass_en;
  assign irq = s.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_mode_hold;
    s.mode_valid |=> s.mode_valid && $stable(s.mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("Mode changed after latch."); // R1

  property p_level;
    !s.error |=> lamps.level_high == ($past(s.margin_s) >= LVL_HIGH)
      && lamps.level_low == ($past(s.margin_s) >= LVL_LOW) && lamps.carrier == ($past(s.margin_s) >= LVL_CARRIER);
  endproperty
  a_level: assert property (p_level) else $error("Level lamps disagree with margin."); // R2

  property p_link;
    ##1 lamps.link == $past(s.pin_s[0]);
  endproperty
  a_link: assert property (p_link) else $error("Link lamp wrong."); // R3

  property p_status;
    ##1 lamps.status == ($past(s.pin_s[1]) && !$past(s.error));
  endproperty
  a_status: assert property (p_status) else $error("Status lamp wrong."); // R4

  property p_pass;
    pass_en |-> lamps.status && carrier_present;
  endproperty
  a_pass: assert property (p_pass) else $error("Data passed without status and carrier."); // R5

  property p_blink;
    s.error |=> lamps.carrier == $past(s.blink) && lamps.level_low == lamps.carrier
      && lamps.level_high == lamps.carrier;
  endproperty
  a_blink: assert property (p_blink) else $error("Fault lamps not blinking in phase."); // R6

  property p_fault;
    fault_now |=> s.error && !laser_en ##1 !laser_en;
  endproperty
  a_fault: assert property (p_fault) else $error("Laser not stopped on fault."); // R7

  property p_err_hold;
    s.error |=> s.error && !laser_en && !lamps.status;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("Error state left without reset."); // R8

  property p_normal;
    s.mode_valid && s.mode == MODE_NORMAL && !s.error && !fault_now |=> lan_link_en && laser_en;
  endproperty
  a_normal: assert property (p_normal) else $error("Normal mode dropped link or laser."); // R9

  property p_drop;
    s.mode_valid && s.mode != MODE_NORMAL && !carrier_now |=> !lan_link_en;
  endproperty
  a_drop: assert property (p_drop) else $error("Wired link kept during interruption."); // R10

  property p_slave;
    s.mode == MODE_SLAVE && !s.pin_s[2] |=> !laser_en;
  endproperty
  a_slave: assert property (p_slave) else $error("Slave emitted without wired link."); // R11

  property p_cd;
    ##1 carrier_present == ($past(s.margin_s) >= LVL_CARRIER);
  endproperty
  a_cd: assert property (p_cd) else $error("Carrier-detect output wrong."); // R15

  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held past one cycle.");

  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("Read data driven outside a reply.");

  property p_settle;
    !s.mode_valid && s.settle == SETTLE_LAST |=> s.mode_valid;
  endproperty
  a_settle: assert property (p_settle) else $error("Mode not latched after settling."); // R1

  property p_sticky;
    events[EV_FAULT] |=> s.irq_stat[EV_FAULT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Fault event lost against a clear.");

  property p_pass_err;
    s.error |=> !pass_en;
  endproperty
  a_pass_err: assert property (p_pass_err) else $error("Data passed in the error state."); // R5

  c_fault: cover property (s.laser_en ##1 s.error);
  c_slave_emit: cover property (s.mode == MODE_SLAVE && laser_en);
  c_master_drop: cover property (s.mode == MODE_MASTER && lan_link_en ##1 !lan_link_en && laser_en);
  c_irq: cover property (!irq ##1 irq);
  c_normal_hold: cover property (s.mode == MODE_NORMAL && lan_link_en && !carrier_present);

endmodule // optical_link_supervisor

/* File: ols_partner.sv */
/*
  Model of the far side: peer optical unit, emission monitor and wired station.
  Assumes the testbench sets the light level, power code and station state.
*/
`timescale 1ns/1ps
module ols_partner
  import ols_pkg::*;
(
  // Testbench controls.
  input wire logic [7:0] light,
  input wire logic [7:0] power,
  input wire logic link_ok,
  input wire logic station_on,
  // Device side.
  input wire logic lan_link_en,
  output logic [7:0] rx_margin,
  output logic [7:0] emit_power,
  output logic peer_link,
  output logic lan_phy_up
);
  // The peer is a normal or master unit that emits whatever its wired link does, as pairing allows.
  assign rx_margin = light;
  // The peer links only while its light reaches the carrier threshold.
  assign peer_link = link_ok && (light >= LVL_CARRIER);
  // A fixed monitor code avoids false faults from sync lag at laser turn-on.
  assign emit_power = power;
  // The station only brings its PHY up while the wired link is presented.
  assign lan_phy_up = station_on && lan_link_en;
endmodule // ols_partner

/* File: optical_link_supervisor_test.sv */
/*
  Self-checking testbench for the optical link supervisor.
  Assumes the partner model on the front-end pins and APB from this bench.
*/
`timescale 1ns/1ps
module optical_link_supervisor_test;
  import ols_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, carrier_present, laser_en, lan_link_en, pass_en, irq;
  logic [1:0] mode_switch = 2'h0;
  logic [7:0] light = 8'h00, power = 8'h80, rx_margin, emit_power;
  logic link_ok = 1'b1, station_on = 1'b1, circuit_ok = 1'b1, peer_link, lan_phy_up;
  lamps_t lamps;
  int fails = 0, total_checks = 0, toggles;
  logic [15:0] seed = 16'h1FF3;
  logic [31:0] rd;
  logic er, prev;

  always #12.5 pclk = ~pclk;

  optical_link_supervisor #(.BLINK_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_switch(mode_switch), .rx_margin(rx_margin), .emit_power(emit_power),
    .peer_link(peer_link), .circuit_ok(circuit_ok), .lan_phy_up(lan_phy_up), .lamps(lamps),
    .carrier_present(carrier_present), .laser_en(laser_en), .lan_link_en(lan_link_en), .pass_en(pass_en),
    .irq(irq));
  ols_partner peer (.light(light), .power(power), .link_ok(link_ok), .station_on(station_on),
    .lan_link_en(lan_link_en), .rx_margin(rx_margin), .emit_power(emit_power), .peer_link(peer_link),
    .lan_phy_up(lan_phy_up));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic lamps_t exp_lamps(input logic [7:0] m, input logic ok, input logic lk);
    lamps_t e;
    e.status = ok;
    e.level_high = m >= LVL_HIGH;
    e.level_low = m >= LVL_LOW;
    e.carrier = m >= LVL_CARRIER;
    e.link = lk;
    return e;
  endfunction

  task automatic end_of_test();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      end_of_test();
    end
  endtask

  task automatic rst(input logic [1:0] m);
    presetn <= 1'b0;
    mode_switch <= m;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  initial begin
    rst(2'h0);
    apb(1'b0, ADDR_PWR_LO, 32'h0);
    chk(rd, 32'(PWR_LO_RESET));
    apb(1'b0, ADDR_PWR_HI, 32'h0);
    chk(rd, 32'(PWR_HI_RESET));
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, ADDR_STATUS, 32'h0);
    chk(32'(er), 32'h1);
    $display("registers done");
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      @(posedge pclk);
      // The first three draws sit exactly on the carrier, low and high thresholds.
      light <= (i < 3) ? LVL_CARRIER + 8'(2 * i) : {4'h0, seed[3:0]};
      circuit_ok <= seed[4];
      link_ok <= seed[5];
      repeat (6) @(posedge pclk);
      chk(32'(lamps), 32'(exp_lamps(light, circuit_ok, link_ok && light >= LVL_CARRIER)));
      chk(32'(carrier_present), 32'(light >= LVL_CARRIER));
      chk(32'(pass_en), 32'(circuit_ok && light >= LVL_CARRIER));
    end
    circuit_ok <= 1'b1;
    $display("lamps done");
    for (int m = 0; m < 3; m++) begin
      light <= 8'h00;
      rst(2'(m));
      mode_switch <= 2'h3 - 2'(m);
      repeat (6) @(posedge pclk);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk(32'(rd[2:0]), 32'({1'b1, 2'(m)}));
      chk(32'({lan_link_en, laser_en}), 32'({m == 0, m != 2}));
      light <= 8'h08;
      // A slave needs the wired link back through the pin synchroniser before it emits.
      repeat (8) @(posedge pclk);
      chk(32'({lan_link_en, laser_en}), 32'h3);
    end
    $display("modes done");
    rst(2'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1);
    apb(1'b1, ADDR_PWR_HI, 32'h20);
    repeat (6) @(posedge pclk);
    chk(32'({laser_en, lamps.status, pass_en, irq}), 32'h1);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'(rd[3]), 32'h1);
    toggles = 0;
    prev = lamps.carrier;
    repeat (20) begin
      @(posedge pclk);
      chk(32'({lamps.level_high, lamps.level_low}), 32'({2{lamps.carrier}}));
      toggles += int'(lamps.carrier !== prev);
      prev = lamps.carrier;
    end
    chk(32'(toggles >= 4), 32'h1);
    apb(1'b1, ADDR_PWR_HI, 32'(PWR_HI_RESET));
    apb(1'b1, ADDR_IRQ_STAT, 32'h1);
    @(posedge pclk);
    chk(32'({irq, laser_en}), 32'h0);
    rst(2'h3);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(32'({rd[3:0], laser_en}), 32'h9);
    $display("fault done");
    end_of_test();
  end
endmodule // optical_link_supervisor_test
